// ### shared/serial_rx_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the serial receiver.
  Assumes a 32-bit classic Wishbone slave with byte addresses; included by bare name.
*/
`ifndef SERIAL_RX_REGS_SVH
`define SERIAL_RX_REGS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define RX_DATA_OFS        4'h0
`define RX_STATUS_OFS      4'h4
`define RX_CONTROL_OFS     4'h8
`define RX_FORMAT_OFS      4'hC

// ==========================================================================
// Status register fields
`define ST_COMPLETE_BIT    7
`define ST_FRAME_ERR_BIT   4
`define ST_OVERRUN_BIT     3
`define ST_PARITY_ERR_BIT  2
`define ST_DOUBLE_BIT      1

// ==========================================================================
// Control register fields
`define CT_IRQ_EN_BIT      7
`define CT_RX_EN_BIT       4
`define CT_NINTH_BIT       1

// ==========================================================================
// Format register fields
`define FM_PAR_EN_BIT      5
`define FM_PAR_ODD_BIT     4
`define FM_STOP_SEL_BIT    3
`define FM_SIZE_HI         2
`define FM_SIZE_LO         0

// ==========================================================================
// Reset values
`define CONTROL_RST        8'h00
`define FORMAT_RST         8'h03
`define STATUS_WR_RST      8'h00

// ==========================================================================
// Oversampling figures and nine-bit size code
`define OVS_NORMAL         5'h10
`define OVS_DOUBLE         5'h08
`define CHAR_SIZE_NINE     3'h7

`endif

// ### shared/serial_rx_pkg.sv
/*
  Types shared by the serial receiver.
  Assumes serial_rx_regs.svh supplies all numeric constants.
*/
package serial_rx_pkg;

  // ==========================================================================
  // Receiver sequence states
  typedef enum logic [2:0]
  {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100
  } rx_state_t;

endpackage

// ### hdl/serial_rx.sv
/*
  Receive side of an asynchronous serial port: start detection, majority voting,
  parity checking, a two-entry receive buffer with per-frame status and a Wishbone slave.
  Assumes a baud sample enable pulse from an external divider at 16x (or 8x) the bit rate.
*/
// ==========================================================================
// Behaviour
// - short frames read zeros in upper bits.
// - ninth bit and errors stored per frame.
// - complete flag shows unread buffer data.
// - disable flushes buffer, clears complete flag.
// - disable abandons frame, releases pin at once.
// - interrupt follows complete flag and enable.
// - error flag writes ignored; write zeros.
// - error flags raise no interrupt themselves.
// - frame error reflects first stop bit.
// - only first stop bit affects frame error.
// - overrun when buffer full, shifter full, start.
// - overrun clears on successful buffer transfer.
// - parity error only when checking was on.
// - parity error valid until frame read.
// - sixteen samples per bit, eight double-speed.
// - start bit accepted by majority of centre samples.
// - each bit decided by centre-sample majority.
// - first stop bit moves shifter to buffer.
`timescale 1ns/1ps
`include "serial_rx_regs.svh"

module serial_rx
  import serial_rx_pkg::*;
#(
  parameter int DEPTH = 2
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        sample_en,
  input  wire logic        rx_pin,
  input  wire logic        global_irq_en,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             rx_complete_irq,
  output logic             rx_pin_claimed
);

  // ==========================================================================
  // Declarations
  rx_state_t        state_q;
  logic             sync1_q, sync2_q;
  logic [4:0]       tick_q;
  logic [3:0]       bit_cnt_q;
  logic [8:0]       shift_q;
  logic [2:0]       votes_q;
  logic             par_bad_q;
  logic             frame_par_en_q;
  logic [7:0]       control_q;
  logic [7:0]       format_q;
  logic             double_q;
  logic [12:0]      fifo_q [DEPTH];
  logic [1:0]       rd_ptr_q, wr_ptr_q, count_q;
  logic             hold_valid_q;
  logic [12:0]      hold_q;
  logic             overrun_q;
  logic             ack_q;
  logic [31:0]      rdata_q;
  logic             irq_q;

  logic             rx_en, par_en, par_odd, majority, bus_req, data_read, push;
  logic [4:0]       ovs, mid_tick;
  logic [3:0]       nbits;
  logic [12:0]      head;
  logic [8:0]       aligned;
  logic [1:0]       cnt_after;
  logic             xfer;

  assign rx_en    = control_q[`CT_RX_EN_BIT];
  assign par_en   = format_q[`FM_PAR_EN_BIT];
  assign par_odd  = format_q[`FM_PAR_ODD_BIT];
  assign ovs      = double_q ? `OVS_DOUBLE : `OVS_NORMAL;
  assign mid_tick = ovs >> 1;
  // Data bit count: 5..8, or 9 in nine-bit mode.
  assign nbits    = (format_q[`FM_SIZE_HI:`FM_SIZE_LO] == `CHAR_SIZE_NINE) ? 4'h9
                  : 4'h5 + {2'b00, format_q[1:0]};
  assign majority = (votes_q[0] & votes_q[1]) | (votes_q[0] & votes_q[2]) | (votes_q[1] & votes_q[2]);
  assign bus_req   = wb_cyc_i & wb_stb_i & ~ack_q;
  assign data_read = bus_req & ~wb_we_i & (wb_adr_i == `RX_DATA_OFS) & (count_q != 2'h0);
  assign head      = fifo_q[rd_ptr_q[0]];
  // Buffer fill after this cycle's pop; the hold stage moves on only when that leaves room.
  assign aligned   = shift_q >> (4'h9 - nbits);
  assign cnt_after = data_read ? count_q - 2'h1 : count_q;
  assign xfer      = hold_valid_q & (cnt_after != 2'(DEPTH));

  // ==========================================================================
  // Pin synchroniser; the first stage feeds only the second.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end
    else
    begin
      sync1_q <= rx_pin;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================================
  // Receive sequencer: start check, bit sampling, parity and stop.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q        <= RX_IDLE;
      tick_q         <= 5'h00;
      bit_cnt_q      <= 4'h0;
      shift_q        <= 9'h000;
      votes_q        <= 3'h0;
      par_bad_q      <= 1'b0;
      frame_par_en_q <= 1'b0;
    end
    else if (!rx_en)
    begin
      state_q <= RX_IDLE;
      tick_q  <= 5'h00;
    end
    else if (sample_en)
    begin
      // Centre samples are mid-1, mid, mid+1 counting the sample after the first low one as one.
      if (tick_q >= mid_tick - 5'h1 && tick_q <= mid_tick + 5'h1)
        votes_q <= {votes_q[1:0], sync2_q};
      case (state_q)
        RX_IDLE:
        begin
          tick_q <= 5'h01;
          if (!sync2_q)
            state_q <= RX_START;
        end
        RX_START:
        begin
          tick_q <= tick_q + 5'h01;
          if (tick_q == mid_tick + 5'h1)
          begin
            if (!((votes_q[0] & votes_q[1]) | (votes_q[0] & sync2_q) | (votes_q[1] & sync2_q)))
            begin
              frame_par_en_q <= par_en;
              par_bad_q      <= par_odd;
              bit_cnt_q      <= 4'h0;
              shift_q        <= 9'h000;
            end
            else
              state_q <= RX_IDLE;
          end
          if (tick_q == ovs)
          begin
            tick_q  <= 5'h01;
            state_q <= RX_DATA;
          end
        end
        RX_DATA, RX_PAR, RX_STOP:
        begin
          tick_q <= (tick_q == ovs) ? 5'h01 : tick_q + 5'h01;
          if (tick_q == mid_tick + 5'h2)
          begin
            if (state_q == RX_DATA)
            begin
              // LSB first: shift in from the top, align at the end.
              shift_q   <= {majority, shift_q[8:1]};
              par_bad_q <= par_bad_q ^ majority;
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            else if (state_q == RX_PAR)
              par_bad_q <= par_bad_q ^ majority;
            if (state_q == RX_STOP)
              state_q <= RX_IDLE;
          end
          if (tick_q == ovs)
          begin
            if (state_q == RX_DATA && bit_cnt_q == nbits)
              state_q <= frame_par_en_q ? RX_PAR : RX_STOP;
            else if (state_q == RX_PAR)
              state_q <= RX_STOP;
          end
        end
        default:
          state_q <= RX_IDLE;
      endcase
    end
  end

  // stop bit vote completes the frame
  assign push = rx_en & sample_en & (state_q == RX_STOP) & (tick_q == mid_tick + 5'h2);

  // ==========================================================================
  // Shift-register hold stage and receive buffer.
  // Entry layout: {frame_err, parity_err, ninth, data[7:0], overrun, pad}; the hold stage has pad in place of overrun.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_ptr_q     <= 2'h0;
      wr_ptr_q     <= 2'h0;
      count_q      <= 2'h0;
      hold_valid_q <= 1'b0;
      hold_q       <= 13'h0000;
      overrun_q    <= 1'b0;
      for (int i = 0; i < DEPTH; i++)
        fifo_q[i] <= 13'h0000;
    end
    else if (!rx_en)
    begin
      rd_ptr_q     <= 2'h0;
      wr_ptr_q     <= 2'h0;
      count_q      <= 2'h0;
      hold_valid_q <= 1'b0;
      overrun_q    <= 1'b0;
    end
    else
    begin
      if (data_read)
        rd_ptr_q <= rd_ptr_q ^ 2'h1;
      if (xfer)
      begin
        fifo_q[wr_ptr_q[0]] <= {hold_q[12:2], overrun_q, 1'b0};
        overrun_q           <= 1'b0;
        wr_ptr_q            <= wr_ptr_q ^ 2'h1;
        hold_valid_q        <= 1'b0;
      end
      // overrun on new start with all storage full; placed last so a set wins.
      if (hold_valid_q && cnt_after == 2'(DEPTH) && state_q == RX_IDLE && sample_en && !sync2_q)
        overrun_q <= 1'b1;
      // A frame that finds the hold stage still occupied is the one lost to the overrun.
      if (push && (!hold_valid_q || xfer))
      begin
        hold_valid_q <= 1'b1;
        // unused upper bits zero; frame error from stop vote; parity gated
        hold_q <= {~majority, frame_par_en_q & par_bad_q, (nbits == 4'h9) & aligned[8], aligned[7:0], 2'b00};
      end
      count_q <= cnt_after + {1'b0, xfer};
    end
  end

  // ==========================================================================
  // Control, format and speed registers written by software.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      control_q <= `CONTROL_RST;
      format_q  <= `FORMAT_RST;
      double_q  <= 1'b0;
    end
    else if (bus_req && wb_we_i && wb_sel_i[0])
    begin
      if (wb_adr_i == `RX_STATUS_OFS)
        double_q <= wb_dat_i[`ST_DOUBLE_BIT];
      if (wb_adr_i == `RX_CONTROL_OFS)
        control_q <= wb_dat_i[7:0];
      if (wb_adr_i == `RX_FORMAT_OFS)
        format_q <= wb_dat_i[7:0];
    end
  end

  // ==========================================================================
  // Wishbone answer: one-cycle ack the edge after the request; unmapped reads give zero.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q   <= bus_req;
      rdata_q <= 32'h0000_0000;
      if (bus_req && !wb_we_i)
      begin
        case (wb_adr_i)
          `RX_DATA_OFS:
            rdata_q[7:0] <= (count_q != 2'h0) ? head[9:2] : 8'h00;
          `RX_STATUS_OFS:
          begin
            // complete flag; flags belong to head entry
            rdata_q[`ST_COMPLETE_BIT]   <= count_q != 2'h0;
            rdata_q[`ST_FRAME_ERR_BIT]  <= (count_q != 2'h0) & head[12];
            rdata_q[`ST_OVERRUN_BIT]    <= (count_q != 2'h0) & head[1];
            rdata_q[`ST_PARITY_ERR_BIT] <= (count_q != 2'h0) & head[11];
            rdata_q[`ST_DOUBLE_BIT]     <= double_q;
          end
          `RX_CONTROL_OFS:
          begin
            rdata_q[7:0]          <= control_q;
            rdata_q[`CT_NINTH_BIT] <= (count_q != 2'h0) & head[10];
          end
          `RX_FORMAT_OFS:
            rdata_q[7:0] <= format_q;
          default:
            rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================================
  // Interrupt and pin ownership outputs, registered.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_q          <= 1'b0;
      rx_pin_claimed <= 1'b0;
    end
    else
    begin
      // level request; error flags not included
      irq_q          <= (count_q != 2'h0) & control_q[`CT_IRQ_EN_BIT] & global_irq_en & rx_en;
      rx_pin_claimed <= rx_en;
    end
  end

  assign wb_ack_o        = ack_q;
  assign wb_dat_o        = rdata_q;
  assign rx_complete_irq = irq_q;

endmodule

// ### dv/serial_rx_checker.sv
/*
  Port-level assertions for the serial receiver.
  Assumes one clock domain and a bind to serial_rx at the foot of this file.
*/
`timescale 1ns/1ps
`include "serial_rx_regs.svh"
module serial_rx_checker (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        sample_en,
  input wire logic        rx_pin,
  input wire logic        global_irq_en,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        rx_complete_irq,
  input wire logic        rx_pin_claimed
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Bus steps
  sequence take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence off_wr_s;
    wb_ack_o && wb_we_i && wb_adr_i == `RX_CONTROL_OFS && wb_sel_i[0] && !wb_dat_i[`CT_RX_EN_BIT];
  endsequence

  // ==========================================================================
  // Assertions
  a_ack_next: assert property (take_s |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");
  a_disable_now: assert property (off_wr_s |-> ##[1:2] !rx_pin_claimed)
    else $error("pin still claimed after disable");
  a_flush_empty: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `RX_STATUS_OFS && !rx_pin_claimed
    |-> !wb_dat_o[`ST_COMPLETE_BIT])
    else $error("complete flag set while disabled");
  a_empty_data: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `RX_DATA_OFS && !rx_pin_claimed
    |-> wb_dat_o == 32'h00000000)
    else $error("data left after disable");
  a_irq_global: assert property (!global_irq_en |=> !rx_complete_irq)
    else $error("interrupt with global enable low");
  a_irq_claimed: assert property (rx_complete_irq |-> rx_pin_claimed)
    else $error("interrupt while receiver disabled");
endmodule

bind serial_rx serial_rx_checker serial_rx_checker_inst (
  .sys_clk(sys_clk), .rst(rst), .sample_en(sample_en), .rx_pin(rx_pin), .global_irq_en(global_irq_en),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_complete_irq(rx_complete_irq),
  .rx_pin_claimed(rx_pin_claimed)
);

// ### dv/serial_tx_model.sv
/*
  Remote serial transmitter driving the receive line.
  Assumes the bench pulses sample_en once per sample; the line idles high.
*/
`timescale 1ns/1ps
module serial_tx_model (
  input  wire logic sys_clk,
  input  wire logic sample_en,
  output logic      line
);
  initial line = 1'b1;

  // Hold one level for a number of sample pulses; called just after a clock edge.
  task automatic hold(input logic lvl, input int n);
    int k;
    k = 0;
    line <= lvl;
    while (k < n)
    begin
      @(posedge sys_clk);
      if (sample_en)
        k++;
    end
  endtask

  // Start bit, then n bits least significant first (stop included), then idle.
  task automatic send(input logic [10:0] bits, input int n, input int spb, input int idle);
    hold(1'b0, spb);
    for (int i = 0; i < n; i++)
      hold(bits[i], spb);
    if (idle > 0)
      hold(1'b1, idle);
  endtask
endmodule

// ### dv/test_serial_rx.sv
/*
  Self-checking bench for the serial receiver: Wishbone tasks plus a line model.
  Assumes the checker is bound inside serial_rx.
*/
`timescale 1ns/1ps
`include "serial_rx_regs.svh"
module test_serial_rx;
  logic        sys_clk, rst, sample_en, rx_pin, global_irq_en;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rx_complete_irq, rx_pin_claimed;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [1:0]  div_q;
  int          n_fail, total_checks, cyc_cnt, spb;

  serial_rx serial_rx_inst (
    .sys_clk(sys_clk), .rst(rst), .sample_en(sample_en), .rx_pin(rx_pin), .global_irq_en(global_irq_en),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_complete_irq(rx_complete_irq),
    .rx_pin_claimed(rx_pin_claimed));
  serial_tx_model serial_tx_model_inst (.sys_clk(sys_clk), .sample_en(sample_en), .line(rx_pin));

  // Clock of 100 ns.
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Sample pulse every fourth clock; a hang is cut short by the cycle ceiling.
  always @(posedge sys_clk)
  begin
    div_q <= div_q + 2'h1;
    sample_en <= (div_q == 2'h3);
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 60000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; released only after ack is sampled high.
  task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h000000, e});
  endtask

  task automatic send(input logic [10:0] b, input int n, input int idle);
    serial_tx_model_inst.send(b, n, spb, idle);
  endtask

  // Main sequence; status is always read before data.
  initial
  begin
    {rst, global_irq_en, sample_en, wb_cyc_i, wb_stb_i, wb_we_i} = 6'b110000;
    {wb_adr_i, wb_sel_i, wb_dat_i, div_q} = {4'h0, 4'hF, 32'h00000000, 2'h0};
    {n_fail, total_checks, cyc_cnt, spb} = {32'd0, 32'd0, 32'd0, 32'd16};
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`RX_CONTROL_OFS, `CONTROL_RST);
    rd(`RX_FORMAT_OFS, `FORMAT_RST);
    rd(`RX_STATUS_OFS, 8'h00);
    rd(4'h1, 8'h00);
    wr(`RX_CONTROL_OFS, 8'h90);
    send({3'h1, 8'hA5}, 9, 2);
    chk({31'h0, rx_complete_irq}, 32'h1);
    rd(`RX_STATUS_OFS, 8'h80);
    rd(`RX_CONTROL_OFS, 8'h90);
    rd(`RX_DATA_OFS, 8'hA5);
    rd(`RX_STATUS_OFS, 8'h00);
    chk({31'h0, rx_complete_irq}, 32'h0);
    send({3'h1, 8'h5A}, 9, 2);
    global_irq_en <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({31'h0, rx_complete_irq}, 32'h0);
    global_irq_en <= 1'b1;
    wr(`RX_CONTROL_OFS, 8'h00);
    @(posedge sys_clk);
    chk({31'h0, rx_pin_claimed}, 32'h0);
    rd(`RX_STATUS_OFS, 8'h00);
    wr(`RX_CONTROL_OFS, 8'h90);
    wr(`RX_FORMAT_OFS, 8'h0B);
    send({3'h2, 8'h55}, 10, 2);
    rd(`RX_STATUS_OFS, 8'h90);
    wr(`RX_STATUS_OFS, 8'h00);
    rd(`RX_STATUS_OFS, 8'h90);
    rd(`RX_DATA_OFS, 8'h55);
    wr(`RX_FORMAT_OFS, `FORMAT_RST);
    for (int i = 0; i < 4; i++)
      send({3'h1, 8'h10 + 8'(i)}, 9, 0);
    serial_tx_model_inst.hold(1'b1, 4);
    rd(`RX_STATUS_OFS, 8'h80);
    rd(`RX_DATA_OFS, 8'h10);
    rd(`RX_STATUS_OFS, 8'h80);
    rd(`RX_DATA_OFS, 8'h11);
    rd(`RX_STATUS_OFS, 8'h88);
    rd(`RX_DATA_OFS, 8'h12);
    rd(`RX_STATUS_OFS, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      wr(`RX_FORMAT_OFS, 8'h23 | {3'h0, k[0], 4'h0});
      send({2'h1, 1'(1 ^ k[0] ^ k[1]), 8'h07}, 10, 2);
      rd(`RX_STATUS_OFS, {5'h10, k[1], 2'h0});
      rd(`RX_DATA_OFS, 8'h07);
    end
    wr(`RX_FORMAT_OFS, 8'h00);
    send({5'h01, 6'h3F}, 6, 2);
    rd(`RX_STATUS_OFS, 8'h80);
    rd(`RX_DATA_OFS, 8'h1F);
    wr(`RX_FORMAT_OFS, 8'h07);
    send({2'h1, 9'h1A5}, 10, 2);
    rd(`RX_STATUS_OFS, 8'h80);
    rd(`RX_CONTROL_OFS, 8'h92);
    rd(`RX_DATA_OFS, 8'hA5);
    wr(`RX_FORMAT_OFS, `FORMAT_RST);
    wr(`RX_STATUS_OFS, 8'h02);
    spb = 8;
    send({3'h1, 8'hC3}, 9, 2);
    rd(`RX_STATUS_OFS, 8'h82);
    rd(`RX_DATA_OFS, 8'hC3);
    spb = 16;
    wr(`RX_STATUS_OFS, 8'h00);
    serial_tx_model_inst.hold(1'b0, 3);
    serial_tx_model_inst.hold(1'b1, 200);
    rd(`RX_STATUS_OFS, 8'h00);
    end_of_test();
  end
endmodule
